// ### shared/ccf_defs.svh
// Constants for the cache control block: sizes, counts, index values, encodings.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CCF_DEFS_SVH
`define CCF_DEFS_SVH
`define CCF_LINES 16
`define CCF_IDX_W 4
`define CCF_TAG_W 8
`define CCF_LAST_IDX 4'hf
`define CCF_IDX_ZERO 4'h0
`define CCF_IDX_ONE 4'h1
// Organisation encodings
`define CCF_ORG_UNIFIED 2'h0
`define CCF_ORG_INSTR 2'h1
`define CCF_ORG_DATA 2'h2
`endif

// ### shared/ccf_pkg.sv
// Types shared by the cache control block and its bench.
// Assumes ccf_defs.svh is on the include path.
`default_nettype none
`include "ccf_defs.svh"
package ccf_pkg;
    // Control register contents
    typedef struct packed {
        logic [1:0] org;
        logic freeze_bit;
        logic clear_all_bit;
        logic instr_only_clear_bit;
        logic data_only_clear_bit;
    } ccf_ctrl_s;
    // One access from the core
    typedef struct packed {
        logic valid;
        logic is_instr;
        logic [`CCF_IDX_W-1:0] idx;
        logic [`CCF_TAG_W-1:0] tag;
    } ccf_acc_s;
    // Answer to an access
    typedef struct packed {
        logic done;
        logic hit;
        logic alloc;
        logic evict;
    } ccf_rsp_s;
    typedef enum logic [1:0] {
        CCF_IDLE = 2'b01,
        CCF_CLEAR = 2'b10
    } ccf_state_e;
    typedef struct packed {
        ccf_state_e st;
        ccf_ctrl_s ctrl;
        logic [`CCF_IDX_W-1:0] cidx;
        logic cl_i;
        logic cl_d;
        logic [`CCF_LINES-1:0] vld;
        logic [`CCF_LINES-1:0] isi;
        logic [`CCF_LINES-1:0][`CCF_TAG_W-1:0] tags;
        ccf_rsp_s rsp;
    } ccf_state_s;
endpackage
`default_nettype wire

// ### hdl/ccf_cache_ctrl.sv
// Cache control: organisation, freeze and whole-cache clear over a tag array.
// Assumes the core writes the control register as a one-cycle strobe and
// issues one access at a time, same clock, synchronous reset.
//
// Contract
// - unified, instruction-only or data-only organisation
// - freeze never replaces a valid line
// - clear-all bit written while idle starts a clear
// - unified clear scoped by instr/data bits
// - partial clear keeps other lines intact
`timescale 1ns/1ps
`default_nettype none
`include "ccf_defs.svh"
module ccf_cache_ctrl (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ctrl_wr,
    input wire ccf_pkg::ccf_ctrl_s ctrl_wdata,
    output ccf_pkg::ccf_ctrl_s cache_ctrl_reg,
    output logic clear_busy,
    input wire ccf_pkg::ccf_acc_s acc,
    output logic acc_ready,
    output ccf_pkg::ccf_rsp_s rsp
);
    import ccf_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ccf_state_s s; // Registered state
    ccf_state_s next_s; // Next state
    logic cacheable; // Access type served by organisation
    logic line_hit; // Tag match on valid line

    // Accesses wait while a clear walks the array
    assign acc_ready = (s.st == CCF_IDLE) && !ctrl_wr;
    assign clear_busy = (s.st == CCF_CLEAR);
    assign cache_ctrl_reg = s.ctrl;
    assign rsp = s.rsp;

    always_comb begin
        case (s.ctrl.org)
            `CCF_ORG_INSTR: cacheable = acc.is_instr;
            `CCF_ORG_DATA: cacheable = !acc.is_instr;
            default: cacheable = 1'b1;
        endcase
    end
    assign line_hit = s.vld[acc.idx] && (s.tags[acc.idx] == acc.tag)
        && (s.isi[acc.idx] == acc.is_instr);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.rsp = '0;
        case (s.st)
            CCF_IDLE: begin
                if (ctrl_wr) begin
                    next_s.ctrl = ctrl_wdata;
                    // Clear bit is an action, not stored state
                    next_s.ctrl.clear_all_bit = 1'b0;
                    if (ctrl_wdata.clear_all_bit) begin
                        next_s.st = CCF_CLEAR;
                        next_s.cidx = `CCF_IDX_ZERO;
                        if (ctrl_wdata.org == `CCF_ORG_UNIFIED) begin
                            next_s.cl_i = !ctrl_wdata.data_only_clear_bit
                                || ctrl_wdata.instr_only_clear_bit;
                            next_s.cl_d = !ctrl_wdata.instr_only_clear_bit
                                || ctrl_wdata.data_only_clear_bit;
                        end else begin
                            next_s.cl_i = 1'b1;
                            next_s.cl_d = 1'b1;
                        end
                    end
                end else if (acc.valid) begin
                    next_s.rsp.done = 1'b1;
                    if (cacheable && line_hit) begin
                        next_s.rsp.hit = 1'b1;
                    end else if (cacheable && !s.vld[acc.idx]) begin
                        // Fill an empty entry
                        next_s.rsp.alloc = 1'b1;
                        next_s.vld[acc.idx] = 1'b1;
                        next_s.isi[acc.idx] = acc.is_instr;
                        next_s.tags[acc.idx] = acc.tag;
                    end else if (cacheable && !s.ctrl.freeze_bit) begin
                        next_s.rsp.alloc = 1'b1;
                        next_s.rsp.evict = 1'b1;
                        next_s.isi[acc.idx] = acc.is_instr;
                        next_s.tags[acc.idx] = acc.tag;
                    end
                end
            end
            CCF_CLEAR: begin
                // only lines in scope are touched
                if ((s.isi[s.cidx] && s.cl_i) || (!s.isi[s.cidx] && s.cl_d)) begin
                    next_s.vld[s.cidx] = 1'b0;
                end
                if (s.cidx == `CCF_LAST_IDX) begin
                    next_s.st = CCF_IDLE;
                end
                next_s.cidx = s.cidx + `CCF_IDX_ONE;
            end
            default: next_s.st = CCF_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s <= '0;
            s.st <= CCF_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // uncached access types
    property p_org_gate;
        @(posedge clk_sys) disable iff (sys_rst)
        (acc_ready && acc.valid && s.ctrl.org == `CCF_ORG_DATA && acc.is_instr)
            |=> rsp.done && !rsp.hit && !rsp.alloc;
    endproperty
    a_org_gate: assert property (p_org_gate) else $error("instr cached in data mode");

    // Instruction-only organisation leaves data accesses uncached
    property p_org_instr;
        @(posedge clk_sys) disable iff (sys_rst)
        (acc_ready && acc.valid && s.ctrl.org == `CCF_ORG_INSTR && !acc.is_instr)
            |=> rsp.done && !rsp.hit && !rsp.alloc && !rsp.evict;
    endproperty
    a_org_instr: assert property (p_org_instr) else $error("data cached in instr mode");

    property p_freeze;
        @(posedge clk_sys) disable iff (sys_rst)
        s.ctrl.freeze_bit |=> !rsp.evict;
    endproperty
    a_freeze: assert property (p_freeze) else $error("eviction while frozen");

    // A frozen miss on a valid line must leave the array untouched
    property p_frz_keep;
        @(posedge clk_sys) disable iff (sys_rst)
        (s.ctrl.freeze_bit && acc_ready && acc.valid && s.vld[acc.idx] && !line_hit)
            |=> $stable(s.vld) && $stable(s.tags) && $stable(s.isi);
    endproperty
    a_frz_keep: assert property (p_frz_keep) else $error("frozen line changed");

    sequence s_clr_req;
        ctrl_wr && ctrl_wdata.clear_all_bit && acc_ready == 1'b0 && s.st == CCF_IDLE;
    endsequence
    // First half of the walk, lines 0 to 7
    sequence s_busy_head;
        clear_busy [*8];
    endsequence
    // Second half, lines 8 to 15, then back to idle
    sequence s_busy_tail;
        clear_busy [*8] ##1 !clear_busy;
    endsequence
    property p_clr_start;
        @(posedge clk_sys) disable iff (sys_rst)
        s_clr_req |=> s_busy_head ##1 s_busy_tail;
    endproperty
    a_clr_start: assert property (p_clr_start) else $error("clear length wrong");

    // Writes in a walk are dropped; a late write could rescope a half-done clear
    property p_clr_refuse;
        @(posedge clk_sys) disable iff (sys_rst)
        (clear_busy && ctrl_wr) |=> $stable(cache_ctrl_reg);
    endproperty
    a_clr_refuse: assert property (p_clr_refuse) else $error("write taken in clear");

    // No access is answered while the array is being walked
    property p_busy_quiet;
        @(posedge clk_sys) disable iff (sys_rst)
        clear_busy |=> !rsp.done;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("answer during clear");

    property p_scope;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_clr_req and (ctrl_wdata.org == `CCF_ORG_UNIFIED
            && ctrl_wdata.instr_only_clear_bit && !ctrl_wdata.data_only_clear_bit))
            |=> s.cl_i && !s.cl_d;
    endproperty
    a_scope: assert property (p_scope) else $error("clear scope wrong");

    // Data-only scope in unified organisation
    property p_scope_d;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_clr_req and (ctrl_wdata.org == `CCF_ORG_UNIFIED
            && ctrl_wdata.data_only_clear_bit && !ctrl_wdata.instr_only_clear_bit))
            |=> !s.cl_i && s.cl_d;
    endproperty
    a_scope_d: assert property (p_scope_d) else $error("data clear scope wrong");

    property p_keep;
        @(posedge clk_sys) disable iff (sys_rst)
        (clear_busy && !s.cl_d && !s.isi[s.cidx] && s.vld[s.cidx])
            |=> s.vld[$past(s.cidx)];
    endproperty
    a_keep: assert property (p_keep) else $error("data line lost in instr clear");

    // Data-only scope leaves instruction lines valid
    property p_keep_i;
        @(posedge clk_sys) disable iff (sys_rst)
        (clear_busy && !s.cl_i && s.isi[s.cidx] && s.vld[s.cidx])
            |=> s.vld[$past(s.cidx)];
    endproperty
    a_keep_i: assert property (p_keep_i) else $error("instr line lost in data clear");

    property p_done;
        @(posedge clk_sys) disable iff (sys_rst)
        (clear_busy && s.cl_i && s.cl_d && s.cidx == `CCF_LAST_IDX) |=> s.vld == '0;
    endproperty
    a_done: assert property (p_done) else $error("line valid after full clear");
endmodule
`default_nettype wire

// ### tb/ccf_core_model.sv
// Core model: issues control writes and single accesses.
// Assumes the bench calls its tasks; pins change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module ccf_core_model (
    input wire logic clk_sys,
    output logic ctrl_wr,
    output ccf_pkg::ccf_ctrl_s ctrl_wdata,
    output ccf_pkg::ccf_acc_s acc,
    input wire ccf_pkg::ccf_rsp_s rsp,
    input wire logic acc_ready,
    output ccf_pkg::ccf_rsp_s got
);
    import ccf_pkg::*;
    // Idle pins at time zero
    initial begin
        ctrl_wr = 1'b0;
        ctrl_wdata = '0;
        acc = '0;
        got = '0;
    end
    // unfreeze with clear, then idle slot
    task automatic ctl(input logic [1:0] org, input logic frz, clr, ii, id);
        @(negedge clk_sys);
        ctrl_wr = 1'b1;
        ctrl_wdata = '{org, frz & ~clr, clr, ii, id};
        @(negedge clk_sys);
        ctrl_wr = 1'b0;
        ctrl_wdata = ~ctrl_wdata;
    endtask
    // One access, held until ready; answer comes one edge later
    task automatic go(input logic ins, input logic [3:0] idx, input logic [7:0] tag);
        int n;
        n = 0;
        @(negedge clk_sys);
        acc = '{1'b1, ins, idx, tag};
        // Bounded hold while a clear or control write blocks the access
        while (acc_ready !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        got = rsp;
        acc = '{1'b0, ins, idx, ~tag}; // Released valid and tag do not keep old value
    endtask
endmodule
`default_nettype wire

// ### tb/tb_ccf_cache_ctrl.sv
// Bench for the cache control: organisation, freeze and clear scope.
// Assumes the core model drives every design input except clock and reset.
`timescale 1ns/1ps
`default_nettype none
module tb_ccf_cache_ctrl;
    import ccf_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic ctrl_wr, clear_busy, acc_ready;
    ccf_ctrl_s ctrl_wdata, cache_ctrl_reg;
    ccf_acc_s acc;
    ccf_rsp_s rsp, got;
    int err_count = 0;
    int checked = 0;
    always #5 clk_sys = ~clk_sys;
    ccf_cache_ctrl i_ccf_cache_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .cache_ctrl_reg(cache_ctrl_reg),
        .clear_busy(clear_busy), .acc(acc), .acc_ready(acc_ready), .rsp(rsp));
    ccf_core_model i_ccf_core_model (.clk_sys(clk_sys), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .acc(acc), .rsp(rsp), .acc_ready(acc_ready), .got(got));
    // ----------------------------
    // Shared tasks
    // ----------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Bounded count of busy cycles; a hang ends the run
    task automatic busy_len(input logic [7:0] exp);
        int n;
        n = 0;
        while (clear_busy === 1'b1 && n < 40) begin
            n++;
            @(negedge clk_sys);
        end
        chk("busy", exp, n[7:0]);
        if (n >= 40) give_verdict();
    endtask
    // Rsp code is {done,hit,alloc,evict}
    task automatic t_org();
        i_ccf_core_model.ctl(2'h0, 0, 0, 0, 0);
        i_ccf_core_model.go(1, 4'h1, 8'h11);
        chk("miss", 8'h0a, 8'(got));
        i_ccf_core_model.go(1, 4'h1, 8'h11);
        chk("hit", 8'h0c, 8'(got));
        i_ccf_core_model.ctl(2'h1, 0, 0, 0, 0);
        chk("org", 8'h10, 8'(cache_ctrl_reg));
        i_ccf_core_model.go(0, 4'h3, 8'h33);
        chk("data in icache", 8'h08, 8'(got));
        i_ccf_core_model.ctl(2'h2, 0, 0, 0, 0);
        chk("org data", 8'h20, 8'(cache_ctrl_reg));
        i_ccf_core_model.go(1, 4'h7, 8'h77);
        chk("instr in dcache", 8'h08, 8'(got));
        i_ccf_core_model.go(0, 4'h7, 8'h77);
        chk("data in dcache", 8'h0a, 8'(got));
        i_ccf_core_model.ctl(2'h0, 0, 0, 0, 0);
        i_ccf_core_model.go(0, 4'h5, 8'h55);
        chk("data fill", 8'h0a, 8'(got));
        $display("t_org done");
    endtask
    task automatic t_frz();
        i_ccf_core_model.ctl(2'h0, 1, 0, 0, 0);
        chk("frz reg", 8'h08, 8'(cache_ctrl_reg));
        i_ccf_core_model.go(1, 4'h1, 8'h22);
        chk("no evict", 8'h08, 8'(got));
        i_ccf_core_model.go(1, 4'h1, 8'h11);
        chk("kept", 8'h0c, 8'(got));
        i_ccf_core_model.go(1, 4'h3, 8'h33);
        chk("free fill", 8'h0a, 8'(got));
        i_ccf_core_model.ctl(2'h0, 0, 0, 0, 0);
        i_ccf_core_model.go(1, 4'h1, 8'h22);
        chk("evict", 8'h0b, 8'(got));
        $display("t_frz done");
    endtask
    task automatic t_clr();
        i_ccf_core_model.ctl(2'h0, 1, 1, 1, 0);
        busy_len(8'd16);
        chk("clr reg", 8'h02, 8'(cache_ctrl_reg));
        i_ccf_core_model.go(1, 4'h1, 8'h11);
        chk("i gone", 8'h0a, 8'(got));
        i_ccf_core_model.go(0, 4'h5, 8'h55);
        chk("d kept", 8'h0c, 8'(got));
        i_ccf_core_model.ctl(2'h0, 0, 1, 0, 1);
        i_ccf_core_model.ctl(2'h2, 0, 0, 0, 0);
        chk("ready in clear", 8'h00, 8'(acc_ready));
        chk("reg kept", 8'h01, 8'(cache_ctrl_reg));
        busy_len(8'd14);
        chk("ready after", 8'h01, 8'(acc_ready));
        i_ccf_core_model.go(1, 4'h1, 8'h11);
        chk("i kept", 8'h0c, 8'(got));
        i_ccf_core_model.go(0, 4'h7, 8'h77);
        chk("d gone", 8'h0a, 8'(got));
        i_ccf_core_model.ctl(2'h0, 0, 1, 0, 0);
        busy_len(8'd16);
        i_ccf_core_model.go(0, 4'h5, 8'h55);
        chk("all gone", 8'h0a, 8'(got));
        $display("t_clr done");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        t_org();
        t_frz();
        t_clr();
        give_verdict();
    end
endmodule
`default_nettype wire
